// file: logic/pci_tail_consts.svh
`ifndef PCI_TAIL_CONSTS_SVH
`define PCI_TAIL_CONSTS_SVH

// ********************************************************
// register map (byte addresses)
// ********************************************************
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define REG_MASK_OFS 8'h08
`define REG_STATE_OFS 8'h0C

// ********************************************************
// field positions
// ********************************************************
`define CTRL_LEN_LSB 0
`define CTRL_LEN_MSB 7
`define CTRL_START_BIT 8
`define EV_END_BIT 0
`define EV_BEAT_BIT 1
`define STATE_CODE_LSB 0
`define STATE_KIND_LSB 4
`define STATE_REMAIN_LSB 8
`define STATE_BUSY_BIT 16

// ********************************************************
// reset values and codes
// ********************************************************
`define LEN_RST 8'h01
`define MASK_RST 2'h0
`define CODE_IDLE 4'h0
`define CODE_BUSY 4'h1
`define CODE_BUS_TERM 4'h2
`define KIND_NONE 2'h0
`define KIND_NORMAL 2'h1
`endif

// file: logic/pci_tail_pkg.sv
package pci_tail_pkg;

  // bus phase of the write engine
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_DATA,
    PH_TURN
  } phase_e;

  // whole state of the burst engine
  typedef struct packed {
    phase_e phase;
    logic [7:0] len;
    logic [7:0] remain;
    logic [7:0] fetch_left;
    logic pend;
    logic irdy_on;
    logic irdy_oe;
    logic frame_on;
    logic bus_oe;
    logic last;
    logic [31:0] ad;
    logic [3:0] cbe_n;
    logic [3:0] code;
    logic [1:0] kind;
    logic [1:0] status;
    logic [1:0] mask;
    logic [31:0] rdata;
  } engine_s;

  // whole state of the parity generator
  typedef struct packed {
    logic par;
    logic oe;
  } parity_s;

endpackage : pci_tail_pkg

// file: logic/pci_drive_if.sv
`timescale 1ns/1ps
// values the engine places on AD and C/BE#, and the parity that follows them
interface pci_drive_if;
  logic [31:0] ad;
  logic [3:0] cbe_n;
  logic ad_oe;
  logic par;
  logic par_oe;

  modport drv (output ad, output cbe_n, output ad_oe, input par, input par_oe);
  modport gen (input ad, input cbe_n, input ad_oe, output par, output par_oe);
endinterface : pci_drive_if

// file: logic/pci_parity_gen.sv
`timescale 1ns/1ps
`include "pci_tail_consts.svh"

module pci_parity_gen (
  input wire logic i_clk,
  input wire logic i_rst,
  pci_drive_if.gen bus
);

  pci_tail_pkg::parity_s s_q;
  pci_tail_pkg::parity_s s_d;

  // ********************************************************
  // even parity, trailing the covered values by one clock
  // ********************************************************

  // parity enable follows the AD enable, so it drops one cycle late
  always_comb
  begin
    s_d = s_q;
    s_d.par = ^{bus.ad, bus.cbe_n};
    s_d.oe = bus.ad_oe;
  end

  // state register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign bus.par = s_q.par;
  assign bus.par_oe = s_q.oe;

endmodule : pci_parity_gen

// file: logic/pci_burst_write_tail.sv
`timescale 1ns/1ps
`include "pci_tail_consts.svh"

module pci_burst_write_tail (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA,
  output logic O_IRQ,
  // local master side
  output logic O_LOCAL_MASTER_READY_N,
  input wire logic [31:0] I_LOCAL_DATA_IN,
  input wire logic [3:0] I_LOCAL_BYTE_ENABLES_IN,
  output logic O_LOCAL_TRANSFER_STROBE_N,
  output logic [7:0] O_REMAINING_BEAT_COUNTER,
  output logic [3:0] O_MASTER_STATE_CODE,
  output logic [1:0] O_MASTER_END_KIND,
  // pci side
  output logic O_FRAME_N_O,
  output logic O_FRAME_N_OE,
  output logic O_IRDY_N_O,
  output logic O_IRDY_N_OE,
  output logic [31:0] O_AD_O,
  output logic O_AD_OE,
  output logic [3:0] O_CBE_N_O,
  output logic O_CBE_N_OE,
  output logic O_PAR_O,
  output logic O_PAR_OE,
  input wire logic I_TRDY_N
);

  // ********************************************************
  // declarations
  // ********************************************************

  pci_tail_pkg::engine_s s_q;
  pci_tail_pkg::engine_s s_d;

  logic complete;
  logic ready_req;
  logic start;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic [1:0] events;
  logic [31:0] state_word;
  // phase and burst decode
  logic in_idle;
  logic in_data;
  logic in_turn;
  logic take_word;
  logic last_fetch;
  logic burst_end;
  logic [7:0] ctrl_len;

  pci_drive_if drive ();

  // ********************************************************
  // phase decode
  // ********************************************************

  // plain flags for each engine phase, so the decode below reads
  // without repeating the enum compares
  assign in_idle = (s_q.phase == pci_tail_pkg::PH_IDLE);
  assign in_data = (s_q.phase == pci_tail_pkg::PH_DATA);
  assign in_turn = (s_q.phase == pci_tail_pkg::PH_TURN);

  // the word asked for last cycle stands on the local inputs now
  assign take_word = in_data && s_q.pend;

  // the word in hand is the last one, so frame must drop with it
  assign last_fetch = (s_q.fetch_left == 8'h01);

  // the final phase completes now; the bus turns around next cycle
  assign burst_end = complete && s_q.last;

  // ********************************************************
  // bus event decode
  // ********************************************************

  // a phase counts only when both ready lines are low in the same cycle
  assign complete = s_q.irdy_on && !I_TRDY_N;

  // ask for the next word as soon as the bus slot is free or freeing;
  // the word then lands one cycle later, which costs one wait per beat;
  // a target that never answers stalls the engine here, with no abort
  assign ready_req = in_data
                     && (s_q.fetch_left != 8'h00)
                     && !s_q.pend
                     && (!s_q.irdy_on || complete);

  // ********************************************************
  // register decode
  // ********************************************************

  assign wr_ctrl = I_REG_WR && (I_REG_ADDR == `REG_CTRL_OFS);
  assign wr_status = I_REG_WR && (I_REG_ADDR == `REG_STATUS_OFS);
  assign wr_mask = I_REG_WR && (I_REG_ADDR == `REG_MASK_OFS);

  // length field of a control write
  assign ctrl_len = I_REG_WDATA[`CTRL_LEN_MSB:`CTRL_LEN_LSB];

  // start only from idle with a non-empty burst; otherwise dropped, not
  // queued, so software polls the busy bit before the next start
  assign start = wr_ctrl
                 && I_REG_WDATA[`CTRL_START_BIT]
                 && (ctrl_len != 8'h00)
                 && in_idle;

  // read view of the engine
  always_comb
  begin
    state_word = '0;
    state_word[`STATE_CODE_LSB +: 4] = s_q.code;
    state_word[`STATE_KIND_LSB +: 2] = s_q.kind;
    state_word[`STATE_REMAIN_LSB +: 8] = s_q.remain;
    state_word[`STATE_BUSY_BIT] = in_data || in_turn; // turnaround still counts as busy
  end

  // ********************************************************
  // next-state logic
  // ********************************************************

  // the burst engine, the sticky events and the register reads
  always_comb
  begin
    s_d = s_q;
    events = 2'b00;
    s_d.pend = ready_req;

    unique case (s_q.phase)
      pci_tail_pkg::PH_IDLE:
      begin
        // initiator-ready and parity drive end here, after turnaround
        s_d.irdy_oe = 1'b0;
        s_d.irdy_on = 1'b0;
        // frame drives at once; the first fetch follows one cycle later
        if (start)
        begin
          s_d.phase = pci_tail_pkg::PH_DATA;
          s_d.len = ctrl_len;
          s_d.remain = ctrl_len;
          s_d.fetch_left = ctrl_len;
          s_d.bus_oe = 1'b1;
          s_d.frame_on = 1'b1;
          s_d.irdy_oe = 1'b1;
          s_d.last = 1'b0;
          s_d.code = `CODE_BUSY;
          s_d.kind = `KIND_NONE;
        end
      end

      pci_tail_pkg::PH_DATA:
      begin
        // word arriving now was asked for last cycle
        if (take_word)
        begin
          s_d.ad = I_LOCAL_DATA_IN;
          s_d.cbe_n = I_LOCAL_BYTE_ENABLES_IN;
          s_d.irdy_on = 1'b1;
          s_d.fetch_left = s_q.fetch_left - 8'h01;
          if (last_fetch)
          begin
            // last word: frame drops together with irdy rising
            s_d.frame_on = 1'b0;
            s_d.last = 1'b1;
          end
        end
        else if (complete)
        begin
          // no word in hand yet: next cycle is a wait
          s_d.irdy_on = 1'b0;
        end
        else if (!s_q.irdy_on)
        begin
          // still short of a word: the bus stays in a wait
          s_d.irdy_on = 1'b0;
        end

        // count at completion, not at fetch, so waits never move the counter
        if (complete)
        begin
          events[`EV_BEAT_BIT] = 1'b1;
          s_d.remain = s_q.remain - 8'h01;
          if (burst_end)
          begin
            s_d.phase = pci_tail_pkg::PH_TURN;
            s_d.bus_oe = 1'b0;
            s_d.frame_on = 1'b0;
            s_d.irdy_on = 1'b0;
            s_d.remain = 8'h00;
            s_d.code = `CODE_BUS_TERM;
            s_d.kind = `KIND_NORMAL;
            events[`EV_END_BIT] = 1'b1;
          end
        end
      end

      pci_tail_pkg::PH_TURN:
      begin
        // irdy still driven high for this one cycle; its drive ends at the
        // next edge so the idle cycle finds it released
        s_d.phase = pci_tail_pkg::PH_IDLE;
        s_d.irdy_on = 1'b0;
        s_d.irdy_oe = 1'b0;
      end

      default:
      begin
        s_d.phase = pci_tail_pkg::PH_IDLE;
      end
    endcase

    // sticky events: a new event beats a clear in the same cycle,
    // so a beat landing during a clear is never lost
    if (wr_status)
    begin
      s_d.status = s_q.status & ~I_REG_WDATA[1:0];
    end
    s_d.status = s_d.status | events;

    // mask only gates the interrupt; events still collect while masked
    if (wr_mask)
    begin
      s_d.mask = I_REG_WDATA[1:0];
    end

    // read data stand for exactly the cycle after the strobe
    s_d.rdata = '0;
    if (I_REG_RD)
    begin
      unique case (I_REG_ADDR)
        `REG_CTRL_OFS:
        begin
          // start reads back as zero; it only lives for its write cycle
          s_d.rdata[`CTRL_LEN_MSB:`CTRL_LEN_LSB] = s_q.len;
        end
        `REG_STATUS_OFS:
        begin
          s_d.rdata[1:0] = s_q.status;
        end
        `REG_MASK_OFS:
        begin
          s_d.rdata[1:0] = s_q.mask;
        end
        `REG_STATE_OFS:
        begin
          s_d.rdata = state_word;
        end
        default:
        begin
          // unmapped addresses read as zero
          s_d.rdata = '0;
        end
      endcase
    end
  end

  // ********************************************************
  // state register
  // ********************************************************

  // every control bit starts parked with the bus released
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      s_q <= '0;
      // bus and handshake parked first, so no line is driven out of reset
      s_q.bus_oe <= 1'b0;
      s_q.irdy_oe <= 1'b0;
      s_q.frame_on <= 1'b0;
      s_q.irdy_on <= 1'b0;
      s_q.pend <= 1'b0;
      s_q.last <= 1'b0;
      s_q.remain <= 8'h00;
      s_q.fetch_left <= 8'h00;
      s_q.status <= 2'b00;
      s_q.rdata <= 32'h0000_0000;
      s_q.phase <= pci_tail_pkg::PH_IDLE;
      s_q.len <= `LEN_RST;
      s_q.cbe_n <= 4'hF;
      s_q.code <= `CODE_IDLE;
      s_q.kind <= `KIND_NONE;
      s_q.mask <= `MASK_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ********************************************************
  // parity
  // ********************************************************

  // the generator sees the registered bus values, exactly what the pins show,
  // so parity always covers what the target latched
  assign drive.ad = s_q.ad;
  assign drive.cbe_n = s_q.cbe_n;
  assign drive.ad_oe = s_q.bus_oe;

  // parity runs a clock behind AD, so its drive outlives AD by one cycle
  pci_parity_gen u_parity (
    .i_clk (I_CLK),
    .i_rst (I_SYS_RST),
    .bus (drive.gen)
  );

  // ********************************************************
  // outputs
  // ********************************************************

  // local handshake
  assign O_LOCAL_MASTER_READY_N = !ready_req;
  assign O_LOCAL_TRANSFER_STROBE_N = !s_q.pend;

  // progress and result
  assign O_REMAINING_BEAT_COUNTER = s_q.remain;
  assign O_MASTER_STATE_CODE = s_q.code;
  assign O_MASTER_END_KIND = s_q.kind;

  // pci lines, all from flip-flops; an enable is high while we drive the line,
  // and a released line rests on the bus pull-up
  assign O_FRAME_N_O = !s_q.frame_on;
  assign O_FRAME_N_OE = s_q.bus_oe;
  assign O_IRDY_N_O = !s_q.irdy_on;
  assign O_IRDY_N_OE = s_q.irdy_oe;
  assign O_AD_O = s_q.ad;
  assign O_AD_OE = s_q.bus_oe;
  assign O_CBE_N_O = s_q.cbe_n;
  assign O_CBE_N_OE = s_q.bus_oe;
  assign O_PAR_O = drive.par;
  assign O_PAR_OE = drive.par_oe;

  // register side; irq is a level, so it drops the cycle after software
  // clears the last unmasked event
  assign O_REG_RDATA = s_q.rdata;
  assign O_IRQ = |(s_q.status & s_q.mask);

endmodule : pci_burst_write_tail

// file: tb/pci_burst_write_tail_asserts.sv
`timescale 1ns/1ps
`include "pci_tail_consts.svh"
// ****
// burst tail checker
// ****
module tail_checker (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic O_LOCAL_MASTER_READY_N,
  input wire logic [31:0] I_LOCAL_DATA_IN,
  input wire logic [3:0] I_LOCAL_BYTE_ENABLES_IN,
  input wire logic O_LOCAL_TRANSFER_STROBE_N,
  input wire logic [7:0] O_REMAINING_BEAT_COUNTER,
  input wire logic [3:0] O_MASTER_STATE_CODE,
  input wire logic [1:0] O_MASTER_END_KIND,
  input wire logic O_FRAME_N_O,
  input wire logic O_FRAME_N_OE,
  input wire logic O_IRDY_N_O,
  input wire logic O_IRDY_N_OE,
  input wire logic [31:0] O_AD_O,
  input wire logic O_AD_OE,
  input wire logic [3:0] O_CBE_N_O,
  input wire logic O_CBE_N_OE,
  input wire logic O_PAR_O,
  input wire logic O_PAR_OE,
  input wire logic I_TRDY_N
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // a phase completes only with both ready lines low
  sequence done_s;
    O_IRDY_N_OE && !O_IRDY_N_O && !I_TRDY_N;
  endsequence
  sequence last_s;
    done_s ##0 O_FRAME_N_O;
  endsequence
  a_strobe_after_ready: assert property (!O_LOCAL_MASTER_READY_N |=>
    !O_LOCAL_TRANSFER_STROBE_N) else $error("no strobe after ready");
  a_wait_while_fetch: assert property (!O_LOCAL_TRANSFER_STROBE_N |-> O_IRDY_N_O)
    else $error("initiator ready while word fetched");
  a_word_forwarded: assert property (!O_LOCAL_TRANSFER_STROBE_N |=> !O_IRDY_N_O &&
    O_AD_O == $past(I_LOCAL_DATA_IN) && O_CBE_N_O == $past(I_LOCAL_BYTE_ENABLES_IN))
    else $error("taken word not on bus");
  a_count_down: assert property (done_s |=>
    O_REMAINING_BEAT_COUNTER == $past(O_REMAINING_BEAT_COUNTER) - 8'h01)
    else $error("counter not decremented");
  a_last_beat: assert property (last_s |->
    O_REMAINING_BEAT_COUNTER == 8'h01 && O_FRAME_N_OE) else $error("frame released early");
  a_turn_release: assert property (last_s |=>
    !O_FRAME_N_OE && !O_AD_OE && !O_CBE_N_OE &&
    O_IRDY_N_O && O_IRDY_N_OE && O_REMAINING_BEAT_COUNTER == 8'h00)
    else $error("bad turnaround");
  a_end_status: assert property (last_s |=> O_MASTER_STATE_CODE == `CODE_BUS_TERM &&
    O_MASTER_END_KIND == `KIND_NORMAL) else $error("bad end status");
  a_idle_release: assert property (last_s ##1 1'b1 |=> !O_IRDY_N_OE && !O_PAR_OE)
    else $error("drive kept in idle");
  a_parity_follow: assert property (O_PAR_OE == $past(O_AD_OE) &&
    (!O_PAR_OE || O_PAR_O == ^{$past(O_AD_O), $past(O_CBE_N_O)})) else $error("bad parity");
  a_hold_in_wait: assert property (O_IRDY_N_OE && !O_IRDY_N_O && I_TRDY_N |=>
    !O_IRDY_N_O && $stable(O_AD_O) && $stable(O_REMAINING_BEAT_COUNTER))
    else $error("phase not held");
endmodule : tail_checker

bind pci_burst_write_tail tail_checker u_chk (.*);

// file: tb/tail_partner.sv
`timescale 1ns/1ps
// ****
// local master and bus target model
// ****
module tail_partner (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_ready_n,
  input wire logic i_bus_on,
  output logic [31:0] o_data,
  output logic [3:0] o_be,
  output logic o_trdy_n
);
  logic [7:0] k_q;
  // stale lines wander so a late fetch never sees a usable word
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      k_q <= 8'h00;
      o_data <= 32'h0000_0000;
      o_be <= 4'hF;
      o_trdy_n <= 1'b1;
    end
    else
    begin
      if (!i_ready_n)
      begin
        o_data <= {16'h1234, 8'h00, k_q};
        o_be <= ~k_q[3:0];
        k_q <= k_q + 8'h01;
      end
      else
      begin
        o_data <= ~o_data;
        o_be <= ~o_be;
      end
      // slow mode asserts trdy only every other cycle; pulled up off the bus
      o_trdy_n <= !i_bus_on | (i_slow & !o_trdy_n);
    end
  end
endmodule : tail_partner

// file: tb/pci_burst_write_tail_tb_top.sv
`timescale 1ns/1ps
`include "pci_tail_consts.svh"
// ****
// bench top
// ****
module pci_burst_write_tail_tb_top;
  logic I_CLK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic [31:0] rdata, ldata, ad;
  logic [3:0] lbe, cbe, code;
  logic [7:0] remain;
  logic [7:0] k = 8'h00;
  logic [1:0] kind;
  logic irq, rdy_n, stb_n, frm, frm_oe, irdy, irdy_oe, ad_oe, trdy_n;
  int n_mismatch = 0;
  int num_checks = 0;
  int beats = 0;

  pci_burst_write_tail DUT (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_REG_ADDR(addr),
    .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_IRQ(irq),
    .O_LOCAL_MASTER_READY_N(rdy_n), .I_LOCAL_DATA_IN(ldata), .I_LOCAL_BYTE_ENABLES_IN(lbe),
    .O_LOCAL_TRANSFER_STROBE_N(stb_n), .O_REMAINING_BEAT_COUNTER(remain),
    .O_MASTER_STATE_CODE(code), .O_MASTER_END_KIND(kind), .O_FRAME_N_O(frm),
    .O_FRAME_N_OE(frm_oe), .O_IRDY_N_O(irdy), .O_IRDY_N_OE(irdy_oe), .O_AD_O(ad),
    .O_AD_OE(ad_oe), .O_CBE_N_O(cbe), .O_CBE_N_OE(), .O_PAR_O(), .O_PAR_OE(),
    .I_TRDY_N(trdy_n));
  tail_partner u_far (.i_clk(I_CLK), .i_rst(I_SYS_RST), .i_slow(slow), .i_ready_n(rdy_n),
    .i_bus_on(frm_oe | irdy_oe), .o_data(ldata), .o_be(lbe), .o_trdy_n(trdy_n));

  initial
  begin
    forever #25 I_CLK = ~I_CLK;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge I_CLK);
    wr <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge I_CLK);
    addr <= a;
    rd <= 1'b1;
    @(posedge I_CLK);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : reg_rd

  // each completed phase must carry the next word in order; settled at the falling edge
  always @(negedge I_CLK)
    if (ad_oe === 1'b1 && irdy === 1'b0 && trdy_n === 1'b0)
    begin
      chk(ad, {16'h1234, 8'h00, k});
      chk({28'h000_0000, cbe}, {28'h000_0000, ~k[3:0]});
      k = k + 8'h01;
      beats++;
    end

  task automatic burst(input logic [7:0] n, input logic s, input logic [1:0] m);
    int t;
    slow <= s;
    reg_wr(`REG_MASK_OFS, {30'h0, m});
    beats = 0;
    reg_wr(`REG_CTRL_OFS, {23'h00_0000, 1'b1, n});
    chk({24'h00_0000, remain}, {24'h00_0000, n});
    // a second start while busy must be dropped and leave the length alone
    reg_wr(`REG_CTRL_OFS, 32'h0000_0105);
    t = 0;
    while (code !== `CODE_BUS_TERM && t < 200)
    begin
      @(negedge I_CLK);
      t++;
    end
    chk({28'h000_0000, code}, 32'h0000_0002);
    chk({30'h0, kind}, 32'h0000_0001);
    chk(32'(beats), {24'h00_0000, n});
    reg_rd(`REG_STATE_OFS, 32'h0000_0012);
    reg_rd(`REG_CTRL_OFS, {24'h00_0000, n});
    reg_rd(`REG_STATUS_OFS, 32'h0000_0003);
    chk({31'h0, irq}, {31'h0, |m});
    reg_wr(`REG_STATUS_OFS, 32'h0000_0001);
    reg_rd(`REG_STATUS_OFS, 32'h0000_0002);
    reg_wr(`REG_STATUS_OFS, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask : burst

  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (8) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    reg_rd(`REG_CTRL_OFS, 32'h0000_0001);
    reg_rd(`REG_STATE_OFS, 32'h0000_0000);
    reg_rd(`REG_MASK_OFS, 32'h0000_0000);
    reg_rd(8'h10, 32'h0000_0000);
    burst(8'h03, 1'b0, 2'h3);
    burst(8'h02, 1'b1, 2'h1);
    burst(8'h01, 1'b0, 2'h0);
    // a zero length start must leave the bus alone
    reg_wr(`REG_CTRL_OFS, 32'h0000_0100);
    repeat (3) @(negedge I_CLK);
    chk({31'h0, frm_oe}, 32'h0000_0000);
    chk({28'h000_0000, code}, 32'h0000_0002);
    report_and_stop();
  end

  // hang guard, far beyond the under a hundred cycles the sequence needs
  initial
  begin
    repeat (4000) @(posedge I_CLK);
    n_mismatch++;
    report_and_stop();
  end
endmodule : pci_burst_write_tail_tb_top
